/* verilog/dspdp_core.sv */
// Arithmetic datapath of a 16-bit fixed-point processor core.
// Assumes a decoder on the same clock drives the control inputs each cycle.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "dspdp_cfg.svh"
module dspdp_core #(
  parameter int NPTR = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input dspdp_pkg::dspdp_alu_ctl_t alu_ctl,
  input dspdp_pkg::dspdp_ptr_ctl_t ptr_ctl,
  input wire logic [15:0] data_read_bus,
  input wire logic ishift_sign_ext,
  input wire logic mcand_en,
  input wire logic mul_en,
  input wire logic mul_signed,
  input wire logic prod_load_en,
  input wire logic st1_wr_en,
  input wire logic [15:0] st1_wr_data,
  input wire logic carry_set_en,
  input wire logic carry_set_value,
  input wire logic out_high_half,
  input wire logic [2:0] out_shift,
  input wire logic [3:0] bit_test_pos,
  input wire logic bit_test_dynamic,
  input wire logic ptr_from_bus,
  output logic [31:0] result_register,
  output logic [15:0] data_write_bus,
  output logic [31:0] product_shifter_out,
  output logic [15:0] status_word_one,
  output logic [15:0] pointer_addr,
  output logic [2:0] pointer_select,
  output logic [15:0] multiplicand_holding,
  output dspdp_pkg::dspdp_status_t status
);
  import dspdp_pkg::*;

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  logic [31:0] input_shifter;
  logic [31:0] product_holding;
  logic [31:0] product_shifter;
  logic [31:0] opnd_a;
  logic [31:0] opnd_b;
  logic [32:0] next_sum;
  logic [31:0] next_acc;
  logic next_carry;
  logic next_ovf;
  logic [4:0] ishift;
  logic [31:0] ishift_src;
  logic [31:0] oshift;
  logic [31:0] alu_res;
  logic alu_carry;
  logic alu_ovf;
  logic carry;
  logic [1:0] product_shift_sel;
  logic ptr_eq;
  logic ptr_lt;
  logic [15:0] bit_vec;
  logic [3:0] bit_pos;
  logic [15:0] next_st1;
  logic [15:0] next_dwb;
  logic [31:0] next_pso;
  dspdp_status_t next_status;

  assign carry = status_word_one[`DSPDP_ST1_CARRY_BIT];
  assign product_shift_sel = status_word_one[`DSPDP_ST1_PM_LO +: 2];

  // Saturating clamp so counts above 16 cannot wrap the shift
  function automatic logic [4:0] clamp_shift(input logic [4:0] n);
    clamp_shift = (n > `DSPDP_ISHIFT_MAX) ? `DSPDP_ISHIFT_MAX : n;
  endfunction

  // ----------------------------------------
  // Input shifter
  // ----------------------------------------
  always_comb begin
    if (alu_ctl.ishift_dynamic) begin
      ishift = {1'b0, multiplicand_holding[`DSPDP_DYN_SHIFT_BITS-1:0]};
    end else begin
      ishift = clamp_shift(alu_ctl.ishift_count);
    end
    if (ishift_sign_ext) begin
      ishift_src = {{16{data_read_bus[15]}}, data_read_bus};
    end else begin
      ishift_src = {16'h0000, data_read_bus};
    end
    input_shifter = ishift_src << ishift;
  end

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  assign opnd_a = result_register;
  assign opnd_b = alu_ctl.b_from_product ? product_shifter : input_shifter;

  // ----------------------------------------
  // Main arithmetic unit
  // ----------------------------------------
  always_comb begin
    next_sum = 33'h0_0000_0000;
    alu_res = opnd_a;
    alu_carry = carry;
    alu_ovf = 1'b0;
    unique case (alu_ctl.alu_op)
      DSPDP_OP_ADD, DSPDP_OP_ADDC: begin
        next_sum = {1'b0, opnd_a} + {1'b0, opnd_b} +
          {32'h0000_0000, (alu_ctl.alu_op == DSPDP_OP_ADDC) & carry};
        alu_res = next_sum[31:0];
        alu_carry = next_sum[32];
        alu_ovf = (opnd_a[31] == opnd_b[31]) && (alu_res[31] != opnd_a[31]);
      end
      DSPDP_OP_SUB, DSPDP_OP_SUBB: begin
        next_sum = {1'b0, opnd_a} + {1'b0, ~opnd_b} +
          {32'h0000_0000, (alu_ctl.alu_op == DSPDP_OP_SUB) | carry};
        alu_res = next_sum[31:0];
        alu_carry = next_sum[32];
        alu_ovf = (opnd_a[31] != opnd_b[31]) && (alu_res[31] != opnd_a[31]);
      end
      DSPDP_OP_AND: alu_res = opnd_a & opnd_b;
      DSPDP_OP_OR: alu_res = opnd_a | opnd_b;
      DSPDP_OP_XOR: alu_res = opnd_a ^ opnd_b;
      DSPDP_OP_LOAD: alu_res = opnd_b;
      default: alu_res = opnd_a;
    endcase
  end

  // ----------------------------------------
  // Result register shifts and rotates
  // ----------------------------------------
  always_comb begin
    next_acc = alu_res;
    next_carry = alu_carry;
    next_ovf = alu_ovf;
    unique case (alu_ctl.acc_shift)
      DSPDP_SH_SFL: begin
        next_acc = {alu_res[30:0], 1'b0};
        next_carry = alu_res[31];
      end
      DSPDP_SH_SFR: begin
        next_acc = {alu_res[31], alu_res[31:1]};
        next_carry = alu_res[0];
      end
      DSPDP_SH_ROL: begin
        next_acc = {alu_res[30:0], carry};
        next_carry = alu_res[31];
      end
      DSPDP_SH_ROR: begin
        next_acc = {carry, alu_res[31:1]};
        next_carry = alu_res[0];
      end
      default: next_acc = alu_res;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_register <= `DSPDP_ACC_RESET;
    end else if (alu_ctl.acc_en) begin
      result_register <= next_acc;
    end
  end

  // ----------------------------------------
  // Status word one
  // ----------------------------------------
  always_comb begin
    next_st1 = status_word_one;
    if (st1_wr_en) begin
      next_st1 = st1_wr_data;
    end
    if (carry_set_en) begin
      next_st1[`DSPDP_ST1_CARRY_BIT] = carry_set_value;
    end
    if (alu_ctl.acc_en) begin
      next_st1[`DSPDP_ST1_CARRY_BIT] = next_carry;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_word_one <= 16'h0000;
    end else begin
      status_word_one <= next_st1;
    end
  end

  // ----------------------------------------
  // Multiplicand register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multiplicand_holding <= `DSPDP_MCAND_RESET;
    end else if (mcand_en) begin
      multiplicand_holding <= data_read_bus;
    end
  end

  dspdp_multiplier_unit u_mul (
    .clk(clk),
    .rst_n(rst_n),
    .mul_en(mul_en),
    .mul_signed(mul_signed),
    .multiplicand_holding(multiplicand_holding),
    .mul_operand(data_read_bus),
    .prod_load_en(prod_load_en),
    .prod_load_value({data_read_bus, data_read_bus}),
    .product_shift_sel(product_shift_sel),
    .product_holding(product_holding),
    .product_shifter(product_shifter)
  );

  dspdp_pointer_unit #(
    .NPTR(NPTR)
  ) u_ptr (
    .clk(clk),
    .rst_n(rst_n),
    .ctl(ptr_ctl),
    .load_value(ptr_from_bus ? data_read_bus : result_register[15:0]),
    .pointer_addr(pointer_addr),
    .pointer_select(pointer_select),
    .cmp_eq(ptr_eq),
    .cmp_lt(ptr_lt)
  );

  // ----------------------------------------
  // Output shifter and bit test
  // ----------------------------------------
  assign oshift = result_register << out_shift;
  assign bit_vec = data_read_bus;
  assign bit_pos = bit_test_dynamic ? multiplicand_holding[3:0] : bit_test_pos;

  always_comb begin
    next_dwb = out_high_half ? oshift[31:16] : oshift[15:0];
    next_pso = product_shifter;
    next_status.zero = (next_acc == 32'h0000_0000);
    next_status.neg = next_acc[31];
    next_status.carry = next_carry;
    next_status.ovf = next_ovf;
    next_status.cmp_eq = ptr_eq;
    next_status.cmp_lt = ptr_lt;
    next_status.bit_tst = bit_vec[4'hF - bit_pos];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_write_bus <= 16'h0000;
      product_shifter_out <= 32'h0000_0000;
      status <= '0;
    end else begin
      data_write_bus <= next_dwb;
      product_shifter_out <= next_pso;
      status <= next_status;
    end
  end
endmodule

/* verilog/dspdp_cfg.svh */
// Constants for the arithmetic datapath: field positions, reset values, shift modes.
// Assumes inclusion by bare name from datapath files.
`ifndef DSPDP_CFG_SVH
`define DSPDP_CFG_SVH
`define DSPDP_ACC_RESET 32'h0000_0000
`define DSPDP_PTR_RESET 16'h0000
`define DSPDP_MCAND_RESET 16'h0000
`define DSPDP_PROD_RESET 32'h0000_0000
`define DSPDP_PM_NONE 2'h0
`define DSPDP_PM_LEFT1 2'h1
`define DSPDP_PM_LEFT4 2'h2
`define DSPDP_PM_RIGHT6 2'h3
`define DSPDP_ST1_CARRY_BIT 9
`define DSPDP_ST1_PM_LO 0
`define DSPDP_ISHIFT_MAX 5'h10
`define DSPDP_DYN_SHIFT_BITS 4
`endif

/* verilog/dspdp_pkg.sv */
// Types shared by the arithmetic datapath files.
// Assumes the configuration header sits beside it.
package dspdp_pkg;
  typedef enum logic [3:0] {
    DSPDP_OP_PASS = 4'h0,
    DSPDP_OP_ADD = 4'h1,
    DSPDP_OP_SUB = 4'h2,
    DSPDP_OP_ADDC = 4'h3,
    DSPDP_OP_SUBB = 4'h4,
    DSPDP_OP_AND = 4'h5,
    DSPDP_OP_OR = 4'h6,
    DSPDP_OP_XOR = 4'h7,
    DSPDP_OP_LOAD = 4'h8
  } dspdp_alu_op_t;

  typedef enum logic [2:0] {
    DSPDP_SH_NONE = 3'h0,
    DSPDP_SH_SFL = 3'h1,
    DSPDP_SH_SFR = 3'h2,
    DSPDP_SH_ROL = 3'h3,
    DSPDP_SH_ROR = 3'h4
  } dspdp_acc_sh_t;

  typedef enum logic [2:0] {
    DSPDP_PU_NONE = 3'h0,
    DSPDP_PU_INC = 3'h1,
    DSPDP_PU_DEC = 3'h2,
    DSPDP_PU_ADD0 = 3'h3,
    DSPDP_PU_SUB0 = 3'h4,
    DSPDP_PU_LOAD = 3'h5
  } dspdp_ptr_op_t;

  typedef struct packed {
    logic acc_en;
    dspdp_alu_op_t alu_op;
    logic b_from_product;
    logic ishift_dynamic;
    logic [4:0] ishift_count;
    dspdp_acc_sh_t acc_shift;
  } dspdp_alu_ctl_t;

  typedef struct packed {
    logic ptr_en;
    dspdp_ptr_op_t ptr_op;
    logic [2:0] ptr_sel_wr;
    logic ptr_sel_en;
    logic [2:0] ptr_sel_new;
  } dspdp_ptr_ctl_t;

  typedef struct packed {
    logic zero;
    logic neg;
    logic carry;
    logic ovf;
    logic cmp_eq;
    logic cmp_lt;
    logic bit_tst;
  } dspdp_status_t;
endpackage

/* verilog/dspdp_pointer_unit.sv */
// Pointer registers with their unsigned address arithmetic unit.
// Assumes the controller issues at most one pointer update per cycle.
`timescale 1ns/1ps
`include "dspdp_cfg.svh"
module dspdp_pointer_unit #(
  parameter int NPTR = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input dspdp_pkg::dspdp_ptr_ctl_t ctl,
  input wire logic [15:0] load_value,
  output logic [15:0] pointer_addr,
  output logic [2:0] pointer_select,
  output logic cmp_eq,
  output logic cmp_lt
);
  import dspdp_pkg::*;

  logic [15:0] ptr [NPTR];
  logic [15:0] pointer_zero_index;
  logic [15:0] cur;
  logic [15:0] next_ptr;
  logic [2:0] next_sel;
  logic [15:0] next_addr;

  assign pointer_zero_index = ptr[0];
  assign cur = ptr[ctl.ptr_sel_wr];

  // ----------------------------------------
  // Pointer arithmetic unit
  // ----------------------------------------
  always_comb begin
    unique case (ctl.ptr_op)
      DSPDP_PU_INC: next_ptr = cur + 16'h0001;
      DSPDP_PU_DEC: next_ptr = cur - 16'h0001;
      DSPDP_PU_ADD0: next_ptr = cur + pointer_zero_index;
      DSPDP_PU_SUB0: next_ptr = cur - pointer_zero_index;
      DSPDP_PU_LOAD: next_ptr = load_value;
      default: next_ptr = cur;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NPTR; g++) begin : g_ptr
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ptr[g] <= `DSPDP_PTR_RESET;
        end else if (ctl.ptr_en && ctl.ptr_sel_wr == 3'(g)) begin
          ptr[g] <= next_ptr;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pointer_select <= 3'h0;
    end else if (ctl.ptr_sel_en) begin
      pointer_select <= ctl.ptr_sel_new;
    end
  end

  // Address register follows the pointer that is active after this edge
  always_comb begin
    next_sel = ctl.ptr_sel_en ? ctl.ptr_sel_new : pointer_select;
    next_addr = ptr[next_sel];
    if (ctl.ptr_en && ctl.ptr_sel_wr == next_sel) begin
      next_addr = next_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pointer_addr <= `DSPDP_PTR_RESET;
    end else begin
      pointer_addr <= next_addr;
    end
  end

  assign cmp_eq = (ptr[pointer_select] == pointer_zero_index);
  assign cmp_lt = (ptr[pointer_select] < pointer_zero_index);
endmodule

/* verilog/dspdp_multiplier_unit.sv */
// 16 by 16 multiplier, product holding register and product shifter.
// Assumes the multiplicand register is held by the parent.
`timescale 1ns/1ps
`include "dspdp_cfg.svh"
module dspdp_multiplier_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mul_en,
  input wire logic mul_signed,
  input wire logic [15:0] multiplicand_holding,
  input wire logic [15:0] mul_operand,
  input wire logic prod_load_en,
  input wire logic [31:0] prod_load_value,
  input wire logic [1:0] product_shift_sel,
  output logic [31:0] product_holding,
  output logic [31:0] product_shifter
);
  import dspdp_pkg::*;

  logic [31:0] product;

  // ----------------------------------------
  // Multiply
  // ----------------------------------------
  always_comb begin
    if (mul_signed) begin
      product = 32'($signed(multiplicand_holding) * $signed(mul_operand));
    end else begin
      product = 32'(multiplicand_holding * mul_operand);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      product_holding <= `DSPDP_PROD_RESET;
    end else if (mul_en) begin
      product_holding <= product;
    end else if (prod_load_en) begin
      product_holding <= prod_load_value;
    end
  end

  // ----------------------------------------
  // Product shifter
  // ----------------------------------------
  always_comb begin
    unique case (product_shift_sel)
      `DSPDP_PM_LEFT1: product_shifter = {product_holding[30:0], 1'b0};
      `DSPDP_PM_LEFT4: product_shifter = {product_holding[27:0], 4'h0};
      `DSPDP_PM_RIGHT6: product_shifter = 32'($signed(product_holding) >>> 6);
      `DSPDP_PM_NONE: product_shifter = product_holding;
    endcase
  end
endmodule

/* tb/dspdp_bus_model.sv */
// Data memory side of the read bus.
// Assumes the bench names the word returned while a read is on.
`timescale 1ns/1ps
module dspdp_bus_model (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [15:0] rd_value,
  output logic [15:0] data_read_bus
);
  logic [15:0] junk = 16'hA5C3;
  // Released bus shows a word that changes every cycle
  always_ff @(posedge clk) begin
    junk <= junk + 16'h3B1D;
  end
  assign data_read_bus = rd_valid ? rd_value : junk;
endmodule

/* tb/dspdp_core_chk.sv */
// Port checker for the arithmetic datapath.
// Assumes a bind to the datapath top, ports by name.
`timescale 1ns/1ps
module dspdp_core_chk (
  input wire logic clk,
  input wire logic rst_n,
  input dspdp_pkg::dspdp_alu_ctl_t alu_ctl,
  input dspdp_pkg::dspdp_ptr_ctl_t ptr_ctl,
  input wire logic [15:0] data_read_bus,
  input wire logic ishift_sign_ext,
  input wire logic mcand_en,
  input wire logic mul_en,
  input wire logic mul_signed,
  input wire logic st1_wr_en,
  input wire logic carry_set_en,
  input wire logic carry_set_value,
  input wire logic out_high_half,
  input wire logic [2:0] out_shift,
  input wire logic [3:0] bit_test_pos,
  input wire logic bit_test_dynamic,
  input wire logic [31:0] result_register,
  input wire logic [15:0] data_write_bus,
  input wire logic [31:0] product_shifter_out,
  input wire logic [15:0] status_word_one,
  input wire logic [15:0] pointer_addr,
  input wire logic [2:0] pointer_select,
  input wire logic [15:0] multiplicand_holding,
  input dspdp_pkg::dspdp_status_t status
);
  import dspdp_pkg::*;
  logic [31:0] ld_exp;
  logic [31:0] osh;
  logic [15:0] out_exp;
  logic [31:0] mul_exp;
  logic bt_exp;
  logic plain;
  assign ld_exp = {16'h0, data_read_bus} << alu_ctl.ishift_count;
  assign osh = result_register << out_shift;
  assign out_exp = out_high_half ? osh[31:16] : osh[15:0];
  assign mul_exp = {16'h0, multiplicand_holding} * {16'h0, data_read_bus};
  assign bt_exp = data_read_bus[4'hF -
    (bit_test_dynamic ? multiplicand_holding[3:0] : bit_test_pos)];
  assign plain = alu_ctl.acc_en && !alu_ctl.b_from_product && !alu_ctl.ishift_dynamic &&
    !ishift_sign_ext && alu_ctl.acc_shift == DSPDP_SH_NONE && alu_ctl.ishift_count <= 5'h10;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  load_shift_a: assert property (
    plain && alu_ctl.alu_op == DSPDP_OP_LOAD |=> result_register == $past(ld_exp))
    else $error("shifted load wrong");
  acc_add_a: assert property (
    plain && alu_ctl.alu_op == DSPDP_OP_ADD |=>
    result_register == $past(result_register) + $past(ld_exp))
    else $error("add wrong");
  acc_hold_a: assert property (!alu_ctl.acc_en |=> $stable(result_register))
    else $error("result moved while idle");
  mcand_load_a: assert property (
    mcand_en |=> multiplicand_holding == $past(data_read_bus))
    else $error("multiplicand wrong");
  mul_plain_a: assert property (
    mul_en && !mul_signed && !st1_wr_en && status_word_one[1:0] == 2'h0 |->
    ##2 product_shifter_out == $past(mul_exp, 2))
    else $error("product wrong");
  carry_set_a: assert property (
    carry_set_en && !alu_ctl.acc_en |=> status_word_one[9] == $past(carry_set_value))
    else $error("carry wrong");
  out_half_a: assert property (rst_n |=> data_write_bus == $past(out_exp))
    else $error("write bus wrong");
  ptr_sel_a: assert property (
    ptr_ctl.ptr_sel_en |=> pointer_select == $past(ptr_ctl.ptr_sel_new))
    else $error("pointer select wrong");
  ptr_step_a: assert property (
    ptr_ctl.ptr_en && ptr_ctl.ptr_op == DSPDP_PU_INC && !ptr_ctl.ptr_sel_en &&
    ptr_ctl.ptr_sel_wr == pointer_select |=> pointer_addr == $past(pointer_addr) + 16'h1)
    else $error("pointer step wrong");
  bit_test_a: assert property (rst_n |=> status.bit_tst == $past(bt_exp))
    else $error("bit test wrong");
endmodule

/* tb/dspdp_core_tb_top.sv */
// Self-checking bench for the arithmetic datapath, random with corner cases.
// Assumes package, design, bus model and checker compiled first.
`timescale 1ns/1ps
module dspdp_core_tb_top;
  import dspdp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dspdp_alu_ctl_t alu_ctl = '0;
  dspdp_ptr_ctl_t ptr_ctl = '0;
  logic rd_valid = 1'b0, ishift_sign_ext = 1'b0, mcand_en = 1'b0, mul_en = 1'b0;
  logic mul_signed = 1'b0, prod_load_en = 1'b0, st1_wr_en = 1'b0, carry_set_en = 1'b0;
  logic carry_set_value = 1'b0, out_high_half = 1'b0, bit_test_dynamic = 1'b0;
  logic ptr_from_bus = 1'b0;
  logic [15:0] rd_value = 16'h0, st1_wr_data = 16'h0;
  logic [2:0] out_shift = 3'h0;
  logic [3:0] bit_test_pos = 4'h0;
  logic [15:0] data_read_bus, data_write_bus, status_word_one, pointer_addr, multiplicand_holding;
  logic [31:0] result_register, product_shifter_out, acc, b, prod;
  logic [2:0] pointer_select;
  dspdp_status_t status;
  logic [32:0] t, r;
  logic [15:0] v, w;
  logic [15:0] ptrs [8];
  logic [4:0] n;
  logic cy, ov;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'hd656;
  dspdp_bus_model dspdp_bus_model_inst (.clk, .rd_valid, .rd_value, .data_read_bus);
  dspdp_core dspdp_core_inst (.clk, .rst_n, .alu_ctl, .ptr_ctl, .data_read_bus, .ishift_sign_ext,
    .mcand_en, .mul_en, .mul_signed, .prod_load_en, .st1_wr_en, .st1_wr_data, .carry_set_en,
    .carry_set_value, .out_high_half, .out_shift, .bit_test_pos, .bit_test_dynamic, .ptr_from_bus,
    .result_register, .data_write_bus, .product_shifter_out, .status_word_one, .pointer_addr,
    .pointer_select, .multiplicand_holding, .status);
  // ----------------------------------------
  // Reference functions
  // ----------------------------------------
  function automatic logic [31:0] ishift(input logic [15:0] d, input logic [4:0] k, input logic s);
    return {s ? {16{d[15]}} : 16'h0, d} << ((k > 5'h10) ? 5'h10 : k);
  endfunction
  function automatic logic [32:0] alu_ref(input dspdp_alu_op_t op, input logic [31:0] a, bb,
                                          input logic c);
    case (op)
      DSPDP_OP_ADD: return {1'b0, a} + {1'b0, bb};
      DSPDP_OP_SUB: return {1'b0, a} + {1'b0, ~bb} + 33'h1;
      DSPDP_OP_ADDC: return {1'b0, a} + {1'b0, bb} + {32'h0, c};
      DSPDP_OP_SUBB: return {1'b0, a} + {1'b0, ~bb} + {32'h0, c};
      DSPDP_OP_AND: return {c, a & bb};
      DSPDP_OP_OR: return {c, a | bb};
      DSPDP_OP_XOR: return {c, a ^ bb};
      DSPDP_OP_LOAD: return {c, bb};
      default: return {c, a};
    endcase
  endfunction
  // Rotates pull in the carry held before the operation
  function automatic logic [32:0] sh_ref(input dspdp_acc_sh_t sh, input logic [32:0] x,
                                         input logic c);
    case (sh)
      DSPDP_SH_SFL: return {x[31], x[30:0], 1'b0};
      DSPDP_SH_SFR: return {x[0], x[31], x[31:1]};
      DSPDP_SH_ROL: return {x[31], x[30:0], c};
      DSPDP_SH_ROR: return {x[0], c, x[31:1]};
      default: return x;
    endcase
  endfunction
  function automatic logic [31:0] pm_ref(input logic [1:0] pm, input logic [31:0] p);
    case (pm)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return 32'($signed(p) >>> 6);
      default: return p;
    endcase
  endfunction
  // ----------------------------------------
  // Drivers and compare
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    alu_ctl.acc_en <= 1'b0;
    ptr_ctl.ptr_en <= 1'b0;
    ptr_ctl.ptr_sel_en <= 1'b0;
    {mcand_en, mul_en, prod_load_en, st1_wr_en, carry_set_en, rd_valid} <= '0;
    #1;
  endtask
  task automatic bus(input logic [15:0] d);
    rd_valid <= 1'b1;
    rd_value <= d;
  endtask
  task automatic alu(input dspdp_alu_op_t op, input logic bp, dyn, input logic [4:0] k,
                     input dspdp_acc_sh_t sh);
    alu_ctl <= '{1'b1, op, bp, dyn, k, sh};
    tick();
  endtask
  task automatic ptr(input dspdp_ptr_op_t op, input logic [2:0] k, input logic sel);
    ptr_ctl <= '{1'b1, op, k, sel, k};
    tick();
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("reset acc", 32'h0, result_register);
    check("reset st1", 32'h0, {status_word_one, multiplicand_holding});
    check("reset ptr", 32'h0, {13'h0, pointer_select, pointer_addr});
    // All ops and accumulator shifts, with loads, carry and output shifter
    for (int i = 0; i < 45; i++) begin
      v = 16'($random(seed));
      n = (i < 3) ? 5'(i * 8) : 5'($random(seed));
      ishift_sign_ext <= v[0];
      bit_test_pos <= n[3:0];
      bus(v);
      alu(DSPDP_OP_LOAD, 1'b0, 1'b0, n, DSPDP_SH_NONE);
      acc = ishift(v, n, v[0]);
      check("load", acc, result_register);
      check("bit test", {31'h0, v[4'hF - n[3:0]]}, {31'h0, status.bit_tst});
      cy = 1'($random(seed));
      carry_set_en <= 1'b1;
      carry_set_value <= cy;
      tick();
      check("carry set", {31'h0, cy}, {31'h0, status_word_one[9]});
      w = 16'($random(seed));
      out_shift <= i[2:0];
      out_high_half <= i[3];
      bus(w);
      alu(dspdp_alu_op_t'(i % 9), 1'b0, 1'b0, n, dspdp_acc_sh_t'(i / 9));
      b = acc << i[2:0];
      check("write bus", {16'h0, i[3] ? b[31:16] : b[15:0]}, {16'h0, data_write_bus});
      b = ishift(w, n, v[0]);
      r = alu_ref(dspdp_alu_op_t'(i % 9), acc, b, cy);
      t = sh_ref(dspdp_acc_sh_t'(i / 9), r, cy);
      ov = (i % 9 inside {1, 3}) ? (acc[31] == b[31]) : (acc[31] != b[31]);
      ov = ov && (i % 9 inside {[1:4]}) && (r[31] != acc[31]);
      acc = t[31:0];
      check("alu", acc, result_register);
      check("flags", 32'({acc == 32'h0, acc[31], t[32], ov}), 32'(status[6:3]));
      if (i % 9 inside {[1:4]} || i >= 9) begin
        check("carry", {31'h0, t[32]}, {31'h0, status_word_one[9]});
      end
    end
    // Every product mode, signed and unsigned
    for (int i = 0; i < 8; i++) begin
      st1_wr_en <= 1'b1;
      st1_wr_data <= {14'h0, i[1:0]};
      tick();
      check("mode", {30'h0, i[1:0]}, {30'h0, status_word_one[1:0]});
      v = (i == 7) ? 16'h8000 : 16'($random(seed));
      w = (i == 7) ? 16'h8000 : 16'($random(seed));
      bus(v);
      mcand_en <= 1'b1;
      tick();
      check("multiplicand", {16'h0, v}, {16'h0, multiplicand_holding});
      bus(w);
      mul_en <= 1'b1;
      mul_signed <= i[2];
      tick();
      tick();
      prod = i[2] ? $signed({{16{v[15]}}, v}) * $signed({{16{w[15]}}, w}) :
        {16'h0, v} * {16'h0, w};
      check("product", pm_ref(i[1:0], prod), product_shifter_out);
    end
    v = 16'($random(seed));
    bus(v);
    prod_load_en <= 1'b1;
    tick();
    tick();
    check("product load", pm_ref(2'h3, {v, v}), product_shifter_out);
    alu(DSPDP_OP_ADD, 1'b1, 1'b0, 5'h0, DSPDP_SH_NONE);
    acc = acc + pm_ref(2'h3, {v, v});
    check("add product", acc, result_register);
    // Dynamic shift and bit position from the multiplicand
    w = 16'($random(seed));
    bus(w);
    mcand_en <= 1'b1;
    tick();
    v = 16'($random(seed));
    bus(v);
    bit_test_dynamic <= 1'b1;
    ishift_sign_ext <= 1'b0;
    alu(DSPDP_OP_LOAD, 1'b0, 1'b1, 5'h1F, DSPDP_SH_NONE);
    acc = ishift(v, {1'b0, w[3:0]}, 1'b0);
    check("dynamic shift", acc, result_register);
    check("dynamic bit", {31'h0, v[4'hF - w[3:0]]}, {31'h0, status.bit_tst});
    // Pointer loads and steps, pointer zero as step size
    ptr_from_bus <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      ptrs[k] = 16'($random(seed));
      bus(ptrs[k]);
      ptr(DSPDP_PU_LOAD, 3'(k), 1'b1);
      check("pointer load", {16'(k), ptrs[k]}, {16'(pointer_select), pointer_addr});
      for (int j = 1; j < 5 && k > 0; j++) begin
        ptr(dspdp_ptr_op_t'(j), 3'(k), 1'b0);
        ptrs[k] += (j == 1) ? 16'h1 : (j == 2) ? 16'hFFFF : (j == 3) ? ptrs[0] : -ptrs[0];
        check("pointer step", {16'h0, ptrs[k]}, {16'h0, pointer_addr});
      end
    end
    ptr_from_bus <= 1'b0;
    ptr(DSPDP_PU_LOAD, 3'h7, 1'b1);
    ptrs[7] = acc[15:0];
    for (int k = 0; k < 8; k++) begin
      ptr(DSPDP_PU_NONE, 3'(k), 1'b1);
      check("pointer keep", {16'h0, ptrs[k]}, {16'h0, pointer_addr});
      tick();
      check("ptr eq", 32'(ptrs[k] == ptrs[0]), 32'(status.cmp_eq));
      check("ptr lt", 32'(ptrs[k] < ptrs[0]), 32'(status.cmp_lt));
    end
    check("acc hold", acc, result_register);
    rst_n <= 1'b0;
    tick();
    rst_n <= 1'b1;
    check("second reset", 32'h0, result_register);
    bus(16'h0001);
    alu(DSPDP_OP_LOAD, 1'b0, 1'b0, 5'h4, DSPDP_SH_NONE);
    check("first load", 32'h10, result_register);
    report_and_stop();
  end
endmodule
bind dspdp_core dspdp_core_chk dspdp_core_chk_inst (.clk, .rst_n, .alu_ctl, .ptr_ctl,
  .data_read_bus, .ishift_sign_ext, .mcand_en, .mul_en, .mul_signed, .st1_wr_en, .carry_set_en,
  .carry_set_value, .out_high_half, .out_shift, .bit_test_pos, .bit_test_dynamic,
  .result_register, .data_write_bus, .product_shifter_out, .status_word_one, .pointer_addr,
  .pointer_select, .multiplicand_holding, .status);
